// *** tqp_pkg.sv ***
// Shared constants and types of the touch post-qualification block.
package tqp_pkg;

  localparam int          CLK_HZ        = 100_000_000;
  localparam int          MS_CYCLES     = CLK_HZ / 1000;
  localparam int          DW            = 16;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0]  ADDR_CTRL     = 6'h00;
  localparam logic [5:0]  ADDR_TIMEOUT  = 6'h04;
  localparam logic [5:0]  ADDR_BZ_HALF  = 6'h08;
  localparam logic [5:0]  ADDR_BZ_DUR   = 6'h0C;
  localparam logic [5:0]  ADDR_PX_THR   = 6'h10;
  localparam logic [5:0]  ADDR_SCAN_EN  = 6'h14;
  localparam logic [5:0]  ADDR_STATUS   = 6'h18;
  localparam logic [5:0]  ADDR_FAIL     = 6'h1C;
  localparam logic [5:0]  ADDR_TDELTA0  = 6'h20;

  // Control register field positions.
  localparam int          CTRL_TO_EN    = 0;
  localparam int          CTRL_MX_EN    = 1;
  localparam int          CTRL_BZ_EN    = 2;
  localparam int          CTRL_ST_EN    = 3;
  localparam int          CTRL_POL_HI   = 4;
  localparam int          CTRL_BZ_OD    = 5;
  localparam int          CTRL_PX_EN    = 6;
  localparam int          CTRL_PX_IDX   = 8;
  localparam int          CTRL_START    = 16;

  // Status and fail register field positions.
  localparam int          STAT_ACT      = 8;
  localparam int          STAT_PROX     = 16;
  localparam int          STAT_PIN      = 17;
  localparam int          STAT_RUN      = 18;
  localparam int          STAT_TEST     = 19;
  localparam int          FAIL_FAST     = 8;

  // Reset values.
  localparam logic [15:0] RST_TO_MS     = 16'h03E8;
  localparam logic [15:0] RST_BZ_DUR    = 16'h0064;
  localparam logic [15:0] RST_PX_THR    = 16'h0100;

  // Buzzer frequency range and derived half-period limits in cycles.
  localparam int          BZ_FMIN_HZ    = 1000;
  localparam int          BZ_FMAX_HZ    = 4000;
  localparam logic [15:0] BZ_HALF_MAX   = 16'(CLK_HZ / (2 * BZ_FMIN_HZ));
  localparam logic [15:0] BZ_HALF_MIN   = 16'(CLK_HZ / (2 * BZ_FMAX_HZ));

  // Self-test error signalling: toggle rate and total time.
  localparam int          ST_RATE_HZ    = 2;
  localparam int          ST_TOTAL_MS   = 2000;
  localparam logic [15:0] ST_HALF_MS    = 16'(1000 / (2 * ST_RATE_HZ));
  localparam logic [3:0]  ST_TOGGLES    = 4'(ST_TOTAL_MS / (1000 / (2 * ST_RATE_HZ)));

  typedef enum {PH_IDLE, PH_TEST, PH_ERR, PH_RUN} tqp_phase_t;

endpackage

// *** tqp_buzzer.sv ***
// Square-wave buzzer generator with duration limit and early stop.
`timescale 1ns/1ps
module tqp_buzzer (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        ms_tick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] half_cycles,
  input  wire logic [15:0] dur_ms,
  output logic             wave,
  output logic             active
);
  import tqp_pkg::*;

  typedef struct packed {
    logic        active;
    logic        wave;
    logic [15:0] half_cnt;
    logic [15:0] ms;
  } tqp_buz_t;

  tqp_buz_t st;
  tqp_buz_t next_st;

  always_comb
  begin
    next_st = st;
    if (start)
    begin
      next_st.active   = 1'b1;
      next_st.wave     = 1'b1;
      next_st.half_cnt = 16'h0000;
      next_st.ms       = 16'h0000;
    end
    else if (st.active)
    begin
      if (stop || st.ms >= dur_ms)
      begin
        next_st.active = 1'b0;
        next_st.wave   = 1'b0;
      end
      else
      begin
        if (st.half_cnt >= half_cycles - 16'h0001)
        begin
          next_st.half_cnt = 16'h0000;
          next_st.wave     = ~st.wave;
        end
        else
          next_st.half_cnt = st.half_cnt + 16'h0001;
        if (ms_tick)
          next_st.ms = st.ms + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign wave   = st.wave;
  assign active = st.active;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_buz_stop_early: assert property ((st.active && stop && !start) |=> !st.active)
    else $error("buzzer kept running after stop");
  a_buz_dur_limit: assert property ((st.active && !start && st.ms >= dur_ms) |=>
                                    !st.wave)
    else $error("buzzer ran past its duration");
endmodule

// *** tqp_top.sv ***
// Touch post-qualifier: proximity, time-out, buzzer, mutual exclusion, self-test.
`timescale 1ns/1ps

// Summary of operation
// - The proximity input is excluded from touch qualification and its thresholds.
// - Proximity state never affects grouping, buzzer, time-out timers or sliders.
// - Proximity detects when its delta reaches the threshold; lower means more range.
// - With time-out enabled each input times its active touch independently.
// - A touch lasting past the time-out is forced to release while still touched.
// - Forced release writes baseline plus configured touch delta for that input.
// - After a forced release the baseline tracks the negative delta downward fast.
// - One global time-out duration applies to every input.
// - With exclusion on, only the externally reported touch runs its timer.
// - With buzzer on, any input newly reported as touched starts the square wave.
// - Buzzer stops when its duration ends or no input is left reported.
// - Buzzer frequency is limited to the range from 1 kHz to 4 kHz.
// - Buzzer pin works as push-pull or as open-drain by configuration.
// - Under exclusion at most one input reported; first stays until released.
// - Simultaneous touches under exclusion report the one with largest delta.
// - When the reported input releases, report the release, then the remaining touch.
// - Among several remaining touches the highest index is reported next.
// - Self-test checks enabled inputs for shorts and opens before scanning starts.
// - Failing sensors are disabled; scanning runs only on inputs left enabled.
// - Self-test errors toggle the buzzer pin at 2 Hz for two seconds.
// - Each input drives its own output pin active on touch, inactive on release.
// - One global setting selects active-high or active-low for all output pins.
module tqp_top #(
  parameter int N         = 7,
  parameter int MS_CYCLES = tqp_pkg::MS_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic [5:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [N-1:0]              qual_touch,
  input  wire logic [N-1:0]              qual_release,
  input  wire logic [N*tqp_pkg::DW-1:0]  touch_delta,
  input  wire logic [N*tqp_pkg::DW-1:0]  baseline,
  input  wire logic [tqp_pkg::DW-1:0]    prox_delta,
  input  wire logic                      selftest_done,
  input  wire logic [N-1:0]              selftest_fault,
  output logic      [N-1:0]              touch_output,
  output logic                           buzzer_o,
  output logic                           buzzer_oe,
  output logic                           force_wr,
  output logic      [2:0]                force_idx,
  output logic      [tqp_pkg::DW-1:0]    force_baseline,
  output logic      [N-1:0]              fast_track,
  output logic                           prox_detect,
  output logic                           scan_run,
  output logic      [N-1:0]              scan_enable
);
  import tqp_pkg::*;

  if (N < 1 || N > 8 || MS_CYCLES < 1)
  begin : g_check
    $error("tqp_top: N must be 1 to 8 and MS_CYCLES at least 1");
  end

  typedef struct packed {
    tqp_phase_t            phase;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  to_en, mx_en, bz_en, st_en, pol_hi, bz_od, px_en;
    logic [2:0]            px_idx;
    logic [15:0]           to_ms, bz_half, bz_dur, px_thr;
    logic [N-1:0]          scan_cfg, fail, act, rep, out, fast;
    logic [N-1:0][DW-1:0]  tdelta, tmr;
    logic                  force_wr;
    logic [2:0]            force_idx;
    logic [DW-1:0]         force_val;
    logic                  prox_det, pin, st_wave, start;
    logic [15:0]           st_ms;
    logic [3:0]            st_tog;
    logic [31:0]           ms_cnt;
  } tqp_state_t;

  tqp_state_t    st;
  tqp_state_t    next_st;
  logic          ms_tick;
  logic          bz_start;
  logic          bz_stop;
  logic          bz_wave;
  logic [N-1:0]  px_mask;
  logic [N-1:0]  en_mask;
  logic [N-1:0]  evt_touch;
  logic [N-1:0]  cnt_on;
  logic          run;

  assign ms_tick  = (st.ms_cnt == 32'(MS_CYCLES - 1));
  assign run      = (st.phase == PH_RUN);
  assign bz_stop  = ~|st.rep;

  for (genvar i = 0; i < N; i++)
  begin : g_in
    assign px_mask[i] = st.px_en && (st.px_idx == 3'(i));
    assign cnt_on[i]  = st.to_en && (st.mx_en ? st.rep[i] : st.act[i]);
  end

  assign en_mask   = st.scan_cfg & ~st.fail & ~px_mask;
  assign evt_touch = qual_touch & en_mask;

  always_comb
  begin
    logic          found;
    logic          forced;
    logic [DW-1:0] best;
    int            pick;
    next_st          = st;
    found            = 1'b0;
    forced           = 1'b0;
    best             = '0;
    pick             = 0;
    next_st.force_wr = 1'b0;
    next_st.start    = 1'b0;
    next_st.ms_cnt   = ms_tick ? 32'h0000_0000 : st.ms_cnt + 32'h0000_0001;

    // One wait state per access: read data is latched, writes land on the ack edge.
    next_st.ack   = (avs_read || avs_write) && !st.ack;
    next_st.rdata = 32'h0000_0000;
    if (avs_read && !st.ack)
    begin
      case (avs_address[5:2])
        ADDR_CTRL[5:2]:
          next_st.rdata = {25'h000_0000, st.px_en, st.bz_od, st.pol_hi, st.st_en,
                           st.bz_en, st.mx_en, st.to_en} | (32'(st.px_idx) << CTRL_PX_IDX);
        ADDR_TIMEOUT[5:2]: next_st.rdata = {16'h0000, st.to_ms};
        ADDR_BZ_HALF[5:2]: next_st.rdata = {16'h0000, st.bz_half};
        ADDR_BZ_DUR[5:2]:  next_st.rdata = {16'h0000, st.bz_dur};
        ADDR_PX_THR[5:2]:  next_st.rdata = {16'h0000, st.px_thr};
        ADDR_SCAN_EN[5:2]: next_st.rdata = 32'(st.scan_cfg);
        ADDR_STATUS[5:2]:
          next_st.rdata = 32'(st.rep) | (32'(st.act) << STAT_ACT)
                        | (32'(st.prox_det) << STAT_PROX) | (32'(st.pin) << STAT_PIN)
                        | (32'(run) << STAT_RUN) | (32'(st.phase == PH_TEST) << STAT_TEST);
        ADDR_FAIL[5:2]:    next_st.rdata = 32'(st.fail) | (32'(st.fast) << FAIL_FAST);
        default:
          if (avs_address[5] && 32'(avs_address[4:2]) < 32'(N))
            next_st.rdata = {16'h0000, st.tdelta[avs_address[4:2]]};
      endcase
    end
    if (avs_write && st.ack)
    begin
      case (avs_address[5:2])
        ADDR_CTRL[5:2]:
        begin
          next_st.to_en  = avs_writedata[CTRL_TO_EN];
          next_st.mx_en  = avs_writedata[CTRL_MX_EN];
          next_st.bz_en  = avs_writedata[CTRL_BZ_EN];
          next_st.st_en  = avs_writedata[CTRL_ST_EN];
          next_st.pol_hi = avs_writedata[CTRL_POL_HI];
          next_st.bz_od  = avs_writedata[CTRL_BZ_OD];
          next_st.px_en  = avs_writedata[CTRL_PX_EN];
          next_st.px_idx = avs_writedata[CTRL_PX_IDX +: 3];
          next_st.start  = avs_writedata[CTRL_START];
        end
        ADDR_TIMEOUT[5:2]: next_st.to_ms = avs_writedata[15:0];
        ADDR_BZ_HALF[5:2]:
          if (avs_writedata[15:0] < BZ_HALF_MIN)
            next_st.bz_half = BZ_HALF_MIN;
          else if (avs_writedata[15:0] > BZ_HALF_MAX)
            next_st.bz_half = BZ_HALF_MAX;
          else
            next_st.bz_half = avs_writedata[15:0];
        ADDR_BZ_DUR[5:2]:  next_st.bz_dur   = avs_writedata[15:0];
        ADDR_PX_THR[5:2]:  next_st.px_thr   = avs_writedata[15:0];
        ADDR_SCAN_EN[5:2]: next_st.scan_cfg = avs_writedata[N-1:0];
        default:
          if (avs_address[5] && 32'(avs_address[4:2]) < 32'(N))
            next_st.tdelta[avs_address[4:2]] = avs_writedata[15:0];
      endcase
    end

    // Start-up sequencing and self-test.
    case (st.phase)
      PH_IDLE:
        if (st.start)
          next_st.phase = st.st_en ? PH_TEST : PH_RUN;
      PH_TEST:
        if (selftest_done)
        begin
          next_st.fail = selftest_fault & st.scan_cfg;
          next_st.st_ms  = 16'h0000;
          next_st.st_tog = 4'h0;
          next_st.phase  = |(selftest_fault & st.scan_cfg) ? PH_ERR : PH_RUN;
        end
      PH_ERR:
        if (ms_tick)
        begin
          if (st.st_ms == ST_HALF_MS - 16'h0001)
          begin
            next_st.st_ms   = 16'h0000;
            next_st.st_wave = ~st.st_wave;
            next_st.st_tog  = st.st_tog + 4'h1;
            if (st.st_tog == ST_TOGGLES - 4'h1)
            begin
              next_st.st_wave = 1'b0;
              next_st.phase   = PH_RUN;
            end
          end
          else
            next_st.st_ms = st.st_ms + 16'h0001;
        end
      PH_RUN: ;
      default: next_st.phase = PH_IDLE;
    endcase

    // Internal qualification state and per-input time-out timers.
    for (int i = 0; i < N; i++)
    begin
      if (!run || qual_release[i])
        next_st.act[i] = 1'b0;
      else if (evt_touch[i])
        next_st.act[i] = 1'b1;
      if (evt_touch[i])
        next_st.fast[i] = 1'b0;
      if (cnt_on[i])
      begin
        if (ms_tick && st.tmr[i] < st.to_ms)
          next_st.tmr[i] = st.tmr[i] + 16'h0001;
      end
      else
        next_st.tmr[i] = '0;
      if (cnt_on[i] && st.tmr[i] >= st.to_ms && !forced)
      begin
        forced              = 1'b1;
        next_st.force_wr    = 1'b1;
        next_st.force_idx   = 3'(i);
        next_st.force_val   = DW'(baseline[i*DW +: DW] + st.tdelta[i]);
        next_st.act[i]      = 1'b0;
        next_st.tmr[i]      = '0;
        next_st.fast[i]     = 1'b1;
      end
    end
    next_st.act = next_st.act & en_mask;

    // Reporting, with the exclusive-group policy when enabled.
    // Entering exclusive mode with several inputs reported drops them all and reselects.
    if (st.mx_en || next_st.mx_en)
    begin
      next_st.rep = $onehot0(st.rep) ? (st.rep & next_st.act) : '0;
      if (st.rep == '0)
      begin
        for (int i = 0; i < N; i++)
          if (evt_touch[i] && next_st.act[i] && (!found || touch_delta[i*DW +: DW] > best))
          begin
            found = 1'b1;
            best  = touch_delta[i*DW +: DW];
            pick  = i;
          end
        if (!found)
          for (int i = 0; i < N; i++)
            if (next_st.act[i])
            begin
              found = 1'b1;
              pick  = i;
            end
        if (found)
          next_st.rep[pick] = 1'b1;
      end
    end
    else
      next_st.rep = next_st.act;
    next_st.out = next_st.pol_hi ? next_st.rep : ~next_st.rep;

    next_st.prox_det = run && st.px_en && (prox_delta >= st.px_thr);
    next_st.pin      = (st.phase == PH_ERR) ? st.st_wave : (st.bz_en && bz_wave);
  end

  assign bz_start = st.bz_en && run && |(next_st.rep & ~st.rep);

  tqp_buzzer u_buzzer (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .ms_tick     (ms_tick),
    .start       (bz_start),
    .stop        (bz_stop),
    .half_cycles (st.bz_half),
    .dur_ms      (st.bz_dur),
    .wave        (bz_wave),
    .active      ()
  );

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st          <= '0;
      st.phase    <= PH_IDLE;
      st.pol_hi   <= 1'b1;
      st.to_ms    <= RST_TO_MS;
      st.bz_half  <= BZ_HALF_MAX;
      st.bz_dur   <= RST_BZ_DUR;
      st.px_thr   <= RST_PX_THR;
      st.scan_cfg <= '1;
      st.out      <= '0;
    end
    else
      st <= next_st;
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign touch_output    = st.out;
  assign buzzer_o        = st.bz_od ? 1'b0 : st.pin;
  assign buzzer_oe       = st.bz_od ? ~st.pin : 1'b1;
  assign force_wr        = st.force_wr;
  assign force_idx       = st.force_idx;
  assign force_baseline  = st.force_val;
  assign fast_track      = st.fast;
  assign prox_detect     = st.prox_det;
  assign scan_run        = run;
  assign scan_enable     = en_mask;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_bus_one_wait: assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer took more than one wait state");
  a_prox_excluded: assert property (st.px_en |-> ((st.act & px_mask) == '0))
    else $error("proximity input entered touch qualification");
  a_mutex_onehot: assert property (st.mx_en |-> $onehot0(st.rep))
    else $error("more than one input reported under exclusion");
  a_release_gap: assert property ((st.mx_en && |st.rep) |=>
                                  (st.rep == $past(st.rep)) || (st.rep == '0))
    else $error("reported input switched without a release cycle");
  a_force_clears: assert property (next_st.force_wr |=>
                                   !st.act[st.force_idx] && st.fast[st.force_idx])
    else $error("forced release left input active");
  a_timer_idle: assert property ((!st.act[0] && !st.rep[0]) |=> st.tmr[0] == '0)
    else $error("timer not cleared after release");
  a_out_polarity: assert property (st.out == (st.pol_hi ? st.rep : ~st.rep))
    else $error("output pins disagree with polarity");
  a_buz_opendrain: assert property (st.bz_od |-> !buzzer_o && (buzzer_oe == !st.pin))
    else $error("open-drain buzzer drove high");
  a_fail_disabled: assert property (run |-> ((st.act & st.fail) == '0))
    else $error("failed sensor still qualifies touches");
  a_err_toggles: assert property ((st.phase == PH_ERR) |-> st.st_tog < ST_TOGGLES)
    else $error("error signalling ran too long");
endmodule

// *** tqp_host_model.sv ***
// Host-side model that resolves the buzzer wire and counts its toggles.
`timescale 1ns/1ps
module tqp_host_model (
  input  wire logic sys_clk,
  input  wire logic clr,
  input  wire logic buzzer_o,
  input  wire logic buzzer_oe,
  output logic      buzzer_pin,
  output int        toggles
);
  logic last;

  // A released open-drain line floats up to the pull-up level.
  assign buzzer_pin = buzzer_oe ? buzzer_o : 1'b1;

  always_ff @(posedge sys_clk)
  begin
    last <= buzzer_pin;
    if (clr)
      toggles <= 0;
    else if (buzzer_pin != last)
      toggles <= toggles + 1;
  end
endmodule

// *** tqp_top_tb.sv ***
// Self-checking bench of the touch post-qualifier.
`timescale 1ns/1ps
module tqp_top_tb;
  import tqp_pkg::*;
  localparam int MSC = 10;
  logic          sys_clk = 0;
  logic          reset_n = 0;
  logic [5:0]    avs_address = 0;
  logic          avs_read = 0;
  logic          avs_write = 0;
  logic [31:0]   avs_writedata = 0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [6:0]    qual_touch = 0;
  logic [6:0]    qual_release = 0;
  logic [111:0]  touch_delta = 0;
  logic [111:0]  baseline = 0;
  logic [15:0]   prox_delta = 0;
  logic          selftest_done = 0;
  logic [6:0]    selftest_fault = 0;
  logic [6:0]    touch_output;
  logic [6:0]    fast_track;
  logic [6:0]    scan_enable;
  logic          buzzer_o;
  logic          buzzer_oe;
  logic          force_wr;
  logic          prox_detect;
  logic          scan_run;
  logic          buzzer_pin;
  logic          clr = 1;
  logic [2:0]    force_idx;
  logic [15:0]   force_baseline;
  int            fails = 0;
  int            cmp_count = 0;
  int            toggles;
  int            n;
  logic [31:0]   q;
  logic [15:0]   td [7];
  logic [15:0]   b;
  logic [15:0]   d;
  logic [15:0]   thr;
  logic [5:0]    ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h3C};
  logic [31:0]   rv [7] = '{32'h0000_0010, 32'(RST_TO_MS), 32'(BZ_HALF_MAX),
                            32'(RST_BZ_DUR), 32'(RST_PX_THR), 32'h0000_007F, 32'h0000_0000};

  always #5 sys_clk = ~sys_clk;

  tqp_top #(.N(7), .MS_CYCLES(MSC)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .qual_touch(qual_touch), .qual_release(qual_release), .touch_delta(touch_delta),
    .baseline(baseline), .prox_delta(prox_delta), .selftest_done(selftest_done),
    .selftest_fault(selftest_fault), .touch_output(touch_output), .buzzer_o(buzzer_o),
    .buzzer_oe(buzzer_oe), .force_wr(force_wr), .force_idx(force_idx),
    .force_baseline(force_baseline), .fast_track(fast_track), .prox_detect(prox_detect),
    .scan_run(scan_run), .scan_enable(scan_enable));

  tqp_host_model host_u (.sys_clk(sys_clk), .clr(clr), .buzzer_o(buzzer_o),
    .buzzer_oe(buzzer_oe), .buzzer_pin(buzzer_pin), .toggles(toggles));

  task automatic complete_run;
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge, then releases it.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic ev(input logic [6:0] t, input logic [6:0] r);
    @(posedge sys_clk);
    qual_touch <= t;
    qual_release <= r;
    @(posedge sys_clk);
    qual_touch <= '0;
    qual_release <= '0;
    #1;
  endtask

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    void'($urandom(32'h9e1fe421));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    clr <= 1'b0;
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 0);
      chk(q, rv[i]);
    end
    bus(1'b1, ADDR_CTRL, 32'h0001_0018);
    @(posedge sys_clk);
    selftest_fault <= 7'h04;
    selftest_done <= 1'b1;
    @(posedge sys_clk);
    selftest_done <= 1'b0;
    n = 0;
    while (scan_run !== 1'b1 && n < 30000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= ST_HALF_MS * ST_TOGGLES * MSC - 15 && n <= ST_HALF_MS * ST_TOGGLES * MSC + 15, 1);
    repeat (2) step;
    chk(toggles, 8);
    chk(scan_enable, 7'h7b);
    bus(1'b0, ADDR_FAIL, 0);
    chk(q[6:0], 7'h04);
    ev(7'h04, 0);
    chk(touch_output, 0);
    ev(7'h03, 0);
    chk(touch_output, 7'h03);
    ev(0, 7'h01);
    chk(touch_output, 7'h02);
    bus(1'b1, ADDR_CTRL, 0);
    step;
    chk(touch_output, 7'h7d);
    ev(0, 7'h02);
    chk(touch_output, 7'h7f);
    bus(1'b1, ADDR_CTRL, 32'h0000_0012);
    for (int i = 0; i < 7; i++)
    begin
      td[i] = (i == 5) ? 16'hffff : 16'($urandom_range(0, 16'h7fff));
      touch_delta[16*i +: 16] <= td[i];
    end
    ev(7'h62, 0);
    chk(touch_output, 7'h20);
    ev(7'h08, 0);
    chk(touch_output, 7'h20);
    ev(0, 7'h40);
    chk(touch_output, 7'h20);
    ev(0, 7'h20);
    chk(touch_output, 0);
    step;
    chk(touch_output, 7'h08);
    ev(0, 7'h08);
    step;
    chk(touch_output, 7'h02);
    ev(0, 7'h02);
    d = 16'($urandom);
    b = 16'($urandom);
    bus(1'b1, ADDR_TDELTA0, {16'h0000, d});
    bus(1'b1, ADDR_TIMEOUT, 32'h0000_0002);
    baseline[15:0] <= b;
    bus(1'b1, ADDR_CTRL, 32'h0000_0011);
    ev(7'h01, 0);
    n = 0;
    while (force_wr !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= MSC && n <= 3 * MSC + 2, 1);
    chk(force_idx, 0);
    chk(force_baseline, 16'(b + d));
    step;
    chk(touch_output, 0);
    chk(fast_track[0], 1);
    ev(0, 7'h01);
    thr = 16'($urandom_range(16, 16'hfff0));
    bus(1'b1, ADDR_PX_THR, {16'h0000, thr});
    bus(1'b1, ADDR_CTRL, 32'h0000_0350);
    prox_delta <= thr - 16'h0001;
    step;
    step;
    chk(prox_detect, 0);
    @(posedge sys_clk);
    prox_delta <= thr;
    step;
    step;
    chk(prox_detect, 1);
    chk(scan_enable, 7'h73);
    ev(7'h08, 0);
    chk(touch_output, 0);
    bus(1'b1, ADDR_BZ_HALF, 0);
    bus(1'b0, ADDR_BZ_HALF, 0);
    chk(q, 32'(BZ_HALF_MIN));
    bus(1'b1, ADDR_BZ_DUR, 32'h0000_0005);
    bus(1'b1, ADDR_CTRL, 32'h0000_0034);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    ev(7'h02, 0);
    repeat (80) step;
    chk(toggles, 2);
    ev(0, 7'h02);
    ev(7'h01, 0);
    repeat (5) step;
    chk({buzzer_o, buzzer_oe, buzzer_pin}, 3'b001);
    bus(1'b0, ADDR_STATUS, 0);
    chk(q, 32'h0006_0101);
    ev(0, 7'h01);
    repeat (3) step;
    chk(toggles, 4);
    complete_run;
  end

  initial
  begin
    #500_000;
    fails++;
    complete_run;
  end
endmodule
